// ===== src/gimc_pkg.sv
package gimc_pkg;
  // ==========================================================
  // register map
  localparam logic [7:0] PINS01_OFS = 8'h0D;
  localparam logic [7:0] PINS23_OFS = 8'h0E;
  localparam logic [7:0] BUSM_OFS = 8'h0F;
  localparam logic [7:0] PINS01_RST = 8'h55;
  localparam logic [7:0] PINS23_RST = 8'h35;
  localparam logic [7:0] BUSM_RST = 8'h00;
  localparam logic [7:0] BUSM_RW_MASK = 8'h1F; // bits 7:5 read only
  // ==========================================================
  // field positions inside a pin pair byte (low pin +0, high pin +4)
  localparam int PIN_DRIVE_BIT = 0;
  localparam int PIN_DIRIN_BIT = 1; // only meaningful for pin 3
  localparam int PIN_FAR_BIT = 2;
  localparam int PIN_LEVEL_BIT = 3;
  localparam int PIN_HI_SHIFT = 4;
  // bus master byte
  localparam int WD_OFF_BIT = 0;
  localparam int WD_FAST_BIT = 1;
  localparam int LOCK_BIT = 2;
  localparam int DLY_LSB = 3;
  // ==========================================================
  // timing
  localparam int CLK_MHZ = 40;
  localparam int SDA_BASE_NS = 350;
  localparam int SDA_STEP_NS = 50;
  localparam int SDA_BASE_CYC = SDA_BASE_NS * CLK_MHZ / 1000;
  localparam int SDA_STEP_CYC = SDA_STEP_NS * CLK_MHZ / 1000;
  localparam int WD_FAST_US = 50;
  localparam int WD_FAST_CYC = WD_FAST_US * CLK_MHZ;
  localparam int WD_LONG_MS = 1000;
  localparam int WD_LONG_CYC = WD_LONG_MS * 1000 * CLK_MHZ;
  localparam int RCV_HALF_US = 5;
  localparam int RCV_HALF_CYC = RCV_HALF_US * CLK_MHZ;
  localparam int RCV_PULSES = 9;
  // ==========================================================
  // register write request
  typedef struct packed {
    logic wr;
    logic from_far; // arrived over the control channel
    logic [7:0] addr;
    logic [7:0] wdata;
  } gimc_wreq_s;

  typedef enum logic [2:0] {
    WD_WATCH = 3'b001,
    WD_LOW = 3'b010,
    WD_HIGH = 3'b100
  } gimc_wd_e;
endpackage

// ===== src/gimc_top.sv
`timescale 1ns/1ps
// Notes on behaviour
// R01: an enabled pin set to output without far control shows its local level, and a cleared enable floats it.
// R02: with far control set the pin is driven as an output with the level sent by the far end; the code drives it only while its enable is set.
// R03: software makes a pin an output before giving it to the far end; pin 3 direction reads 1 for input and resets to input.
// R04: the two bit delay code adds 50 ns steps to the sda output delay, from 350 ns up to 500 ns.
// R05: with the lock bit set, register writes coming over the control channel are dropped.
// R06: the lock bit never stops forwarding of far requests to local bus slaves.
// R07: the bus watchdog expires after 50 us with the speed bit set and after 1 s otherwise.
// R08: the watchdog off bit stops the watchdog while it is 1.
// R09: an expiry with sda high marks the bus as free.
// R10: an expiry with sda low starts a recovery of nine scl clock pulses.
// R11: reserved writable bits store and return data, reserved read only bits read zero, none has an effect.
module gimc_top #(
  parameter int WD_LONG_CYC = gimc_pkg::WD_LONG_CYC,
  parameter int WD_FAST_CYC = gimc_pkg::WD_FAST_CYC,
  parameter int RCV_HALF_CYC = gimc_pkg::RCV_HALF_CYC
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire gimc_pkg::gimc_wreq_s wreq,
  input wire logic [7:0] rd_addr,
  output logic [7:0] rdata_ff,
  input wire logic fwd_req,
  output logic fwd_ack_ff,
  input wire logic [3:0] far_level,
  input wire logic [3:0] pin_in,
  output logic [3:0] pin_out_ff,
  output logic [3:0] pin_oe_ff,
  input wire logic sda_src,
  output logic sda_out_ff,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic scl_oe_ff,
  output logic bus_free_ff,
  output logic pin3_sample_ff
);
  localparam int CW = $clog2(WD_LONG_CYC + 1);
  localparam int HW = $clog2(RCV_HALF_CYC + 1);
  localparam int SH = gimc_pkg::SDA_BASE_CYC + 3 * gimc_pkg::SDA_STEP_CYC;

  // ==========================================================
  // registers
  logic [7:0] p01_ff, p23_ff, bm_ff;
  logic [7:0] nxt_p01, nxt_p23, nxt_bm, nxt_rdata;
  logic nxt_fwd_ack, wr_ok;

  // write decode; far writes dropped while locked
  always_comb begin
    wr_ok = wreq.wr && !(wreq.from_far && bm_ff[gimc_pkg::LOCK_BIT]); // R05
    nxt_p01 = p01_ff;
    nxt_p23 = p23_ff;
    nxt_bm = bm_ff;
    if (wr_ok) begin
      case (wreq.addr)
        gimc_pkg::PINS01_OFS: nxt_p01 = wreq.wdata; // R11
        gimc_pkg::PINS23_OFS: nxt_p23 = wreq.wdata;
        gimc_pkg::BUSM_OFS: nxt_bm = wreq.wdata & gimc_pkg::BUSM_RW_MASK; // R11
        default: nxt_bm = bm_ff;
      endcase
    end
    case (rd_addr)
      gimc_pkg::PINS01_OFS: nxt_rdata = p01_ff;
      gimc_pkg::PINS23_OFS: nxt_rdata = p23_ff;
      gimc_pkg::BUSM_OFS: nxt_rdata = bm_ff;
      default: nxt_rdata = 8'h00;
    endcase
    nxt_fwd_ack = fwd_req; // R06
  end

  // register state
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      p01_ff <= gimc_pkg::PINS01_RST;
      p23_ff <= gimc_pkg::PINS23_RST; // R03
      bm_ff <= gimc_pkg::BUSM_RST;
      rdata_ff <= 8'h00;
      fwd_ack_ff <= 1'b0;
    end else begin
      p01_ff <= nxt_p01;
      p23_ff <= nxt_p23;
      bm_ff <= nxt_bm;
      rdata_ff <= nxt_rdata;
      fwd_ack_ff <= nxt_fwd_ack;
    end
  end

  // ==========================================================
  // pins
  logic [3:0] drive_on, far_ctl, local_lvl, dir_out;
  logic [3:0] nxt_pin_out, nxt_pin_oe;
  logic nxt_pin3_sample;

  // field gather and drive select
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      drive_on[i] = (i < 2) ? p01_ff[gimc_pkg::PIN_DRIVE_BIT + 4 * (i % 2)]
                            : p23_ff[gimc_pkg::PIN_DRIVE_BIT + 4 * (i % 2)];
      far_ctl[i] = (i < 2) ? p01_ff[gimc_pkg::PIN_FAR_BIT + 4 * (i % 2)]
                           : p23_ff[gimc_pkg::PIN_FAR_BIT + 4 * (i % 2)];
      local_lvl[i] = (i < 2) ? p01_ff[gimc_pkg::PIN_LEVEL_BIT + 4 * (i % 2)]
                             : p23_ff[gimc_pkg::PIN_LEVEL_BIT + 4 * (i % 2)];
      dir_out[i] = 1'b1;
    end
    dir_out[3] = !p23_ff[gimc_pkg::PIN_DIRIN_BIT + gimc_pkg::PIN_HI_SHIFT];
    for (int i = 0; i < 4; i++) begin
      nxt_pin_oe[i] = drive_on[i] && (far_ctl[i] || dir_out[i]); // R01 R02
      nxt_pin_out[i] = far_ctl[i] ? far_level[i] : local_lvl[i]; // R02
    end
    nxt_pin3_sample = dir_out[3] ? pin3_sample_ff : pin_in[3];
  end

  // pin outputs
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      pin_out_ff <= 4'h0;
      pin_oe_ff <= 4'h0;
      pin3_sample_ff <= 1'b0;
    end else begin
      pin_out_ff <= nxt_pin_out;
      pin_oe_ff <= nxt_pin_oe;
      pin3_sample_ff <= nxt_pin3_sample;
    end
  end

  // ==========================================================
  // sda output delay line
  logic [SH-1:0] sh_ff, nxt_sh;
  logic nxt_sda_out;
  logic [1:0] dly;
  logic [4:0] age_ff, nxt_age; // cycles since reset, saturating

  // tap moves by one step per code value
  always_comb begin
    dly = bm_ff[gimc_pkg::DLY_LSB +: 2];
    nxt_age = (age_ff == 5'(SH)) ? age_ff : age_ff + 5'h1;
    nxt_sh = {sh_ff[SH-2:0], sda_src};
    nxt_sda_out = sh_ff[gimc_pkg::SDA_BASE_CYC - 2
                        + gimc_pkg::SDA_STEP_CYC * int'(dly)]; // R04
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      sh_ff <= '1;
      sda_out_ff <= 1'b1;
      age_ff <= 5'h0;
    end else begin
      sh_ff <= nxt_sh;
      sda_out_ff <= nxt_sda_out;
      age_ff <= nxt_age;
    end
  end

  // ==========================================================
  // bus watchdog and recovery
  gimc_pkg::gimc_wd_e wd_ff, nxt_wd;
  logic [CW-1:0] cnt_ff, nxt_cnt, limit;
  logic [HW-1:0] ph_ff, nxt_ph;
  logic [3:0] np_ff, nxt_np;
  logic scl_q_ff, sda_q_ff, nxt_free, nxt_scl_oe, act, expire, wd_off;

  // idle count, expiry and pulse train
  always_comb begin
    wd_off = bm_ff[gimc_pkg::WD_OFF_BIT];
    limit = bm_ff[gimc_pkg::WD_FAST_BIT] ? CW'(WD_FAST_CYC)
                                         : CW'(WD_LONG_CYC); // R07
    act = (scl_in != scl_q_ff) || (sda_in != sda_q_ff);
    expire = 1'b0;
    nxt_wd = wd_ff;
    nxt_cnt = cnt_ff;
    nxt_ph = ph_ff;
    nxt_np = np_ff;
    nxt_free = bus_free_ff && !act;
    case (wd_ff)
      gimc_pkg::WD_WATCH: begin
        nxt_cnt = act ? '0 : cnt_ff + 1'b1;
        if (!act && cnt_ff + 1'b1 >= limit) begin
          expire = 1'b1;
          nxt_cnt = '0;
          if (sda_in) begin
            nxt_free = 1'b1; // R09
          end else begin
            nxt_wd = gimc_pkg::WD_LOW; // R10
            nxt_ph = '0;
            nxt_np = 4'h0;
          end
        end
      end
      gimc_pkg::WD_LOW: begin
        nxt_ph = ph_ff + 1'b1;
        if (ph_ff + 1'b1 >= HW'(RCV_HALF_CYC)) begin
          nxt_ph = '0;
          nxt_wd = gimc_pkg::WD_HIGH;
        end
      end
      gimc_pkg::WD_HIGH: begin
        nxt_ph = ph_ff + 1'b1;
        if (ph_ff + 1'b1 >= HW'(RCV_HALF_CYC)) begin
          nxt_ph = '0;
          nxt_np = np_ff + 4'h1;
          nxt_wd = (np_ff == 4'(gimc_pkg::RCV_PULSES - 1))
                   ? gimc_pkg::WD_WATCH : gimc_pkg::WD_LOW; // R10
        end
      end
      default: nxt_wd = gimc_pkg::WD_WATCH;
    endcase
    if (wd_off) begin
      nxt_wd = gimc_pkg::WD_WATCH; // R08
      nxt_cnt = '0;
      nxt_free = 1'b0;
      expire = 1'b0;
    end
    nxt_scl_oe = (nxt_wd == gimc_pkg::WD_LOW);
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      wd_ff <= gimc_pkg::WD_WATCH;
      cnt_ff <= '0;
      ph_ff <= '0;
      np_ff <= 4'h0;
      scl_q_ff <= 1'b1;
      sda_q_ff <= 1'b1;
      bus_free_ff <= 1'b0;
      scl_oe_ff <= 1'b0;
    end else begin
      wd_ff <= nxt_wd;
      cnt_ff <= nxt_cnt;
      ph_ff <= nxt_ph;
      np_ff <= nxt_np;
      scl_q_ff <= scl_in;
      sda_q_ff <= sda_in;
      bus_free_ff <= nxt_free;
      scl_oe_ff <= nxt_scl_oe;
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  sequence wd_low_start;
    expire && !sda_in;
  endsequence

  local_drive_a: assert property ( // R01
    drive_on[0] && !far_ctl[0] |=> pin_oe_ff[0] && pin_out_ff[0] == $past(local_lvl[0]))
    else $error("local level not driven");
  tristate_a: assert property (!drive_on[2] |=> !pin_oe_ff[2]) // R01
    else $error("pin not floated");
  far_drive_a: assert property ( // R02
    drive_on[1] && far_ctl[1] |=> pin_oe_ff[1] && pin_out_ff[1] == $past(far_level[1]))
    else $error("far level not driven");
  sda_delay_a: assert property ( // R04
    age_ff == 5'(SH) && $past(dly) == 2'h0
    |-> sda_out_ff == $past(sda_src, 14))
    else $error("sda delay wrong");
  far_lock_a: assert property ( // R05
    wreq.wr && wreq.from_far && bm_ff[gimc_pkg::LOCK_BIT] |=> $stable(p01_ff) && $stable(p23_ff))
    else $error("locked far write landed");
  fwd_pass_a: assert property (fwd_req |=> fwd_ack_ff) // R06
    else $error("forward blocked");
  fast_limit_a: assert property ( // R07
    bm_ff[gimc_pkg::WD_FAST_BIT] && $past(bm_ff[gimc_pkg::WD_FAST_BIT]) |-> cnt_ff < CW'(WD_FAST_CYC))
    else $error("fast watchdog overran");
  wd_off_a: assert property (wd_off |=> !scl_oe_ff && !bus_free_ff) // R08
    else $error("watchdog acted while off");
  bus_free_a: assert property (expire && sda_in |=> bus_free_ff) // R09
    else $error("free bus not flagged");
  recover_a: assert property ( // R10
    wd_low_start ##1 (!wd_off) [*2] |-> scl_oe_ff [*2])
    else $error("recovery not started");
  rsvd_zero_a: assert property (rdata_ff[7:5] == 3'h0 || $past(rd_addr) != gimc_pkg::BUSM_OFS) // R11
    else $error("read only bits not zero");
endmodule // gimc_top

// ===== tb/gimc_far_model.sv
`timescale 1ns/1ps
// ==========================================================
// far end stand-in: pin levels and forwarded requests
module gimc_far_model (
  input wire logic mclk,
  output logic [3:0] far_level,
  output logic fwd_req
);
  // quiet until a scenario asks for traffic
  initial begin
    far_level = 4'h0;
    fwd_req = 1'b0;
  end
  // new pin levels sent from the far end
  task automatic send_level(input logic [3:0] v);
    @(posedge mclk) #2 far_level = v;
  endtask
  // one-cycle request toward a local bus slave
  task automatic forward();
    @(posedge mclk) #2 fwd_req = 1'b1;
    @(posedge mclk) #2 fwd_req = 1'b0;
  endtask
endmodule // gimc_far_model

// ===== tb/tb_top.sv
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin errors++; \
  $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
// ==========================================================
// bench for the pin and bus master setup block
module tb_top;
  logic mclk, sys_rst, fwd_req, fwd_ack, sda_src, sda_out, scl_in, sda_in;
  logic scl_oe, bus_free, pin3_smp, p;
  gimc_pkg::gimc_wreq_s wreq;
  logic [7:0] rd_addr, rdata, d;
  logic [3:0] far_level, ext_pins, pin_in, pin_out, pin_oe;
  int errors, tests_run, cyc, n;
  // wire levels: the device wins where it drives, scl is pulled up
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_pins);
  assign scl_in = ~scl_oe;
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  gimc_top #(.WD_LONG_CYC(3000), .RCV_HALF_CYC(4)) dut_u (
    .mclk(mclk), .sys_rst(sys_rst), .wreq(wreq), .rd_addr(rd_addr),
    .rdata_ff(rdata), .fwd_req(fwd_req), .fwd_ack_ff(fwd_ack),
    .far_level(far_level), .pin_in(pin_in), .pin_out_ff(pin_out),
    .pin_oe_ff(pin_oe), .sda_src(sda_src), .sda_out_ff(sda_out),
    .scl_in(scl_in), .sda_in(sda_in), .scl_oe_ff(scl_oe),
    .bus_free_ff(bus_free), .pin3_sample_ff(pin3_smp));
  gimc_far_model far_u (.mclk(mclk), .far_level(far_level),
    .fwd_req(fwd_req));
  // ========================================================
  // access tasks
  task automatic step(input int k);
    repeat (k) @(posedge mclk);
    #2;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v,
                    input logic far);
    @(posedge mclk) #2 wreq = '{1'b1, far, a, v};
    @(posedge mclk) #2 wreq.wr = 1'b0;
    step(1);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    @(posedge mclk) #2 rd_addr = a;
    @(posedge mclk) #2 d = rdata;
    `CHK(d, e)
  endtask
  // count quiet cycles until the watchdog acts
  task automatic wd_wait(output int c);
    c = 0;
    while (bus_free !== 1'b1 && scl_oe !== 1'b1 && c < 5000) begin
      @(posedge mclk) #2 c++;
    end
  endtask
  task automatic finish_test();
    $display("errors %0d checks %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // hang guard
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      finish_test();
    end
  end
  // ========================================================
  // scenarios
  initial begin
    sys_rst = 1'b1;
    wreq = '0;
    rd_addr = 8'h00;
    ext_pins = 4'h8;
    sda_src = 1'b1;
    sda_in = 1'b1;
    errors = 0;
    tests_run = 0;
    cyc = 0;
    repeat (5) @(posedge mclk);
    #2 sys_rst = 1'b0;
    rdchk(gimc_pkg::PINS01_OFS, 8'h55);
    rdchk(gimc_pkg::PINS23_OFS, 8'h35);
    rdchk(gimc_pkg::BUSM_OFS, 8'h00);
    rdchk(8'h20, 8'h00);
    `CHK(pin_oe, 4'h7)
    `CHK(pin3_smp, 1'b1)
    // pins 0..2 reset as outputs, so far control is legal at once
    far_u.send_level(4'h5);
    step(1);
    `CHK(pin_out[2:0], 3'h5)
    wr(gimc_pkg::PINS01_OFS, 8'h2B, 1'b0);
    `CHK(pin_oe[1:0], 2'b01)
    `CHK(pin_out[0], 1'b1)
    rdchk(gimc_pkg::PINS01_OFS, 8'h2B);
    // lock, then a far write must be dropped while forwarding goes on
    wr(gimc_pkg::BUSM_OFS, 8'hFD, 1'b0);
    rdchk(gimc_pkg::BUSM_OFS, 8'h1D);
    wr(gimc_pkg::PINS01_OFS, 8'h00, 1'b1);
    rdchk(gimc_pkg::PINS01_OFS, 8'h2B);
    far_u.forward();
    `CHK(fwd_ack, 1'b1)
    wr(gimc_pkg::BUSM_OFS, 8'h01, 1'b0);
    wr(gimc_pkg::PINS01_OFS, 8'h00, 1'b1);
    rdchk(gimc_pkg::PINS01_OFS, 8'h00);
    `CHK(pin_oe[1:0], 2'b00)
    // pin 3 as output low, then back to input
    wr(gimc_pkg::PINS23_OFS, 8'h10, 1'b0);
    ext_pins = 4'h0; // outside level drops while pin 3 drives
    step(1);
    `CHK(pin_oe[3:2], 2'b10)
    `CHK(pin_out[3], 1'b0)
    `CHK(pin3_smp, 1'b1)
    wr(gimc_pkg::PINS23_OFS, 8'h30, 1'b0);
    step(1);
    `CHK(pin_oe[3], 1'b0)
    `CHK(pin3_smp, 1'b0)
    // every sda delay code, watchdog off
    for (int k = 0; k < 4; k++) begin
      wr(gimc_pkg::BUSM_OFS, 8'(k * 8 + 1), 1'b0);
      step(30);
      sda_src = ~sda_src;
      n = 0;
      while (sda_out !== sda_src && n < 40) begin
        @(posedge mclk) #2 n++;
      end
      `CHK(n, 14 + 2 * k)
    end
    // fast watchdog with sda stuck low: recovery pulses
    wr(gimc_pkg::BUSM_OFS, 8'h02, 1'b0);
    sda_in = 1'b0;
    wd_wait(n);
    `CHK(n inside {[1990:2010]}, 1'b1)
    n = 1;
    p = 1'b1;
    repeat (150) begin
      step(1);
      if (scl_oe === 1'b1 && p === 1'b0) n++;
      p = scl_oe;
    end
    `CHK(n, 9)
    // sda released: bus judged free
    sda_in = 1'b1;
    wd_wait(n);
    `CHK(n inside {[1990:2010]}, 1'b1)
    `CHK({bus_free, scl_oe}, 2'b10)
    // slow watchdog
    wr(gimc_pkg::BUSM_OFS, 8'h00, 1'b0);
    sda_in = 1'b0;
    step(1);
    sda_in = 1'b1;
    wd_wait(n);
    `CHK(n inside {[2990:3010]}, 1'b1)
    // watchdog off: no verdict and no recovery
    wr(gimc_pkg::BUSM_OFS, 8'h01, 1'b0);
    `CHK(bus_free, 1'b0)
    sda_in = 1'b0;
    step(3100);
    `CHK({bus_free, scl_oe}, 2'b00)
    finish_test();
  end
endmodule // tb_top
